/* File: hdl/sbt_defs.vh */
// constants for the memory boundary-scan test port
// assumes inclusion by every design file of the test port
`ifndef SBT_DEFS_VH
`define SBT_DEFS_VH

`define SBT_IR_W        3
`define SBT_IR_CAPTURE  3'h1
`define SBT_OP_EXTEST   3'h0
`define SBT_OP_IDCODE   3'h1
`define SBT_OP_SAMPLEZ  3'h2
`define SBT_OP_SAMPLE   3'h3
`define SBT_OP_BYPASS   3'h7
`define SBT_BSR_LEN     110
`define SBT_OE_CELL     109
`define SBT_ID_W        32
`define SBT_RESET_TMS   5

`endif

/* File: hdl/sbt_sync.v */
// two-stage synchroniser for one level from outside the clock domain
// assumes a free-running system clock
`timescale 1ns/100ps
`default_nettype none
module sbt_sync #(
  parameter RESET_VAL = 1'b0
) (
  // clock, reset and enable
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire ce_in,
  // level
  input  wire d_in,
  output reg  q_out
);
  reg meta_q;

  // first stage is read only by the second
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RESET_VAL;
      q_out  <= RESET_VAL;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // sbt_sync
`default_nettype wire

/* File: hdl/sbt_tap.v */
// boundary-scan test access port of the memory device
// assumes test pins arrive unsynchronised; test clock far slower than clk_in
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defs.vh"
module sbt_tap #(
  parameter BSR_LEN = `SBT_BSR_LEN,
  parameter OE_CELL = `SBT_OE_CELL,
  parameter [31:0] ID_VALUE = 32'h0000_0001 // arbitrary identity value
) (
  // clock, reset, enable
  input  wire               clk_in,
  input  wire               rst_n_in,
  input  wire               ce_in,
  // test pins (undriven pins read as high outside the block)
  input  wire               tck_in,
  input  wire               tms_in,
  input  wire               tdi_in,
  output reg                tdo_out,
  output reg                tdo_oe_out,
  // ball ring
  input  wire [BSR_LEN-1:0] ring_in,
  output reg  [BSR_LEN-1:0] ring_drive_out,
  output reg                extest_out,
  output reg                q_oe_out,
  output reg  [2:0]         ir_out
);
  // one-hot controller states, one flip-flop per state
  localparam [15:0] S_TLR = 16'h0001; // test-logic-reset
  localparam [15:0] S_RTI = 16'h0002; // run-test/idle
  localparam [15:0] S_SDS = 16'h0004; // select-DR-scan
  localparam [15:0] S_CDR = 16'h0008; // capture-DR
  localparam [15:0] S_SDR = 16'h0010; // shift-DR
  localparam [15:0] S_E1D = 16'h0020; // exit1-DR
  localparam [15:0] S_PDR = 16'h0040; // pause-DR
  localparam [15:0] S_E2D = 16'h0080; // exit2-DR
  localparam [15:0] S_UDR = 16'h0100; // update-DR
  localparam [15:0] S_SIS = 16'h0200; // select-IR-scan
  localparam [15:0] S_CIR = 16'h0400; // capture-IR
  localparam [15:0] S_SIR = 16'h0800; // shift-IR
  localparam [15:0] S_E1I = 16'h1000; // exit1-IR
  localparam [15:0] S_PIR = 16'h2000; // pause-IR
  localparam [15:0] S_E2I = 16'h4000; // exit2-IR
  localparam [15:0] S_UIR = 16'h8000; // update-IR

  // synchronised pins and edge detection
  wire               tck_s;
  wire               tms_s;
  wire               tdi_s;
  wire [BSR_LEN-1:0] ring_s;
  reg                tck_q;
  wire               rise;
  wire               fall;
  // controller
  reg  [15:0]        st_q;
  reg  [15:0]        st_d;
  // scan registers
  reg  [2:0]         irs_q;
  reg                byp_q;
  reg  [31:0]        id_q;
  reg  [BSR_LEN-1:0] bsr_q;
  // decode and serial source
  wire               sel_id;
  wire               sel_bsr;
  wire               sel_byp;
  wire               shift_ir;
  wire               shift_dr;
  reg                sdo_d;

  // test clock crosses into clk_in; its edges are found after two flops
  sbt_sync #(
    .RESET_VAL (1'b0)
  ) u_tck (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .d_in     (tck_in),
    .q_out    (tck_s)
  );

  // mode select resets high, as its pull-up holds an idle pin
  sbt_sync #(
    .RESET_VAL (1'b1)
  ) u_tms (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .d_in     (tms_in),
    .q_out    (tms_s)
  );

  // serial data in resets high for the same reason
  sbt_sync #(
    .RESET_VAL (1'b1)
  ) u_tdi (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .d_in     (tdi_in),
    .q_out    (tdi_s)
  );

  // ball ring crosses too; a ball moving during capture may land either
  // way, which is the same uncertainty the balls themselves carry
  genvar gi;
  generate
    for (gi = 0; gi < BSR_LEN; gi = gi + 1) begin : g_ring
      sbt_sync #(
        .RESET_VAL (1'b0)
      ) u_ring (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .d_in     (ring_in[gi]),
        .q_out    (ring_s[gi])
      );
    end
  endgenerate

  // previous synchronised test clock; resets low like the idle pin,
  // so releasing reset never looks like a rise
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tck_q <= 1'b0;
    end else if (ce_in) begin
      tck_q <= tck_s;
    end
  end

  // one-cycle strobes at each seen test clock edge
  assign rise = tck_s & ~tck_q;
  assign fall = ~tck_s & tck_q;

  // next controller state from sampled mode select
  always @* begin
    case (st_q)
      S_TLR:   st_d = tms_s ? S_TLR : S_RTI;
      S_RTI:   st_d = tms_s ? S_SDS : S_RTI;
      S_SDS:   st_d = tms_s ? S_SIS : S_CDR;
      S_CDR:   st_d = tms_s ? S_E1D : S_SDR;
      S_SDR:   st_d = tms_s ? S_E1D : S_SDR;
      S_E1D:   st_d = tms_s ? S_UDR : S_PDR;
      S_PDR:   st_d = tms_s ? S_E2D : S_PDR;
      S_E2D:   st_d = tms_s ? S_UDR : S_SDR;
      S_UDR:   st_d = tms_s ? S_SDS : S_RTI;
      S_SIS:   st_d = tms_s ? S_TLR : S_CIR;
      S_CIR:   st_d = tms_s ? S_E1I : S_SIR;
      S_SIR:   st_d = tms_s ? S_E1I : S_SIR;
      S_E1I:   st_d = tms_s ? S_UIR : S_PIR;
      S_PIR:   st_d = tms_s ? S_E2I : S_PIR;
      S_E2I:   st_d = tms_s ? S_UIR : S_SIR;
      S_UIR:   st_d = tms_s ? S_SDS : S_RTI;
      default: st_d = S_TLR;
    endcase
  end

  // controller register; power-up reset lands in test-logic-reset
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= S_TLR;
    end else if (ce_in && rise) begin
      st_q <= st_d;
    end
  end

  // instruction decode picks the single data register;
  // reserved codes fall to bypass so the chain never breaks
  assign sel_id   = (ir_out == `SBT_OP_IDCODE);
  assign sel_bsr  = (ir_out == `SBT_OP_EXTEST) |
                    (ir_out == `SBT_OP_SAMPLEZ) |
                    (ir_out == `SBT_OP_SAMPLE);
  assign sel_byp  = ~sel_id & ~sel_bsr;
  assign shift_ir = (st_q == S_SIR);
  assign shift_dr = (st_q == S_SDR);

  // instruction shifter: capture loads 01 low, shift moves toward lsb
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irs_q <= `SBT_OP_IDCODE;
    end else if (ce_in && rise) begin
      if (st_q == S_CIR) begin
        irs_q <= `SBT_IR_CAPTURE;
      end else if (shift_ir) begin
        irs_q <= {tdi_s, irs_q[2:1]};
      end
    end
  end

  // active instruction: moves only at update-IR or on entering reset,
  // so a half-shifted code never reaches the decode
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ir_out <= `SBT_OP_IDCODE;
    end else if (ce_in && rise) begin
      if (st_d == S_TLR) begin
        ir_out <= `SBT_OP_IDCODE;
      end else if (st_q == S_UIR) begin
        ir_out <= irs_q;
      end
    end
  end

  // one-cell bypass: cleared at capture, then a single-cycle path
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byp_q <= 1'b0;
    end else if (ce_in && rise && sel_byp) begin
      if (st_q == S_CDR) begin
        byp_q <= 1'b0;
      end else if (shift_dr) begin
        byp_q <= tdi_s;
      end
    end
  end

  // identification register: hardwired value taken at capture
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      id_q <= 32'h0000_0000;
    end else if (ce_in && rise && sel_id) begin
      if (st_q == S_CDR) begin
        id_q <= ID_VALUE;
      end else if (shift_dr) begin
        id_q <= {tdi_s, id_q[31:1]};
      end
    end
  end

  // boundary register: one cell per ball, spare balls included
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bsr_q <= {BSR_LEN{1'b0}};
    end else if (ce_in && rise && sel_bsr) begin
      if (st_q == S_CDR) begin
        bsr_q <= ring_s;
      end else if (shift_dr) begin
        bsr_q <= {tdi_s, bsr_q[BSR_LEN-1:1]};
      end
    end
  end

  // preload latches change only under sample or extest; the reset
  // value keeps the read outputs released until a preload sets the cell
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ring_drive_out <= {BSR_LEN{1'b0}};
    end else if (ce_in && rise && st_q == S_UDR) begin
      if (sel_bsr && ir_out != `SBT_OP_SAMPLEZ) begin
        ring_drive_out <= bsr_q;
      end
    end
  end

  // ring-side controls follow the active instruction one cycle later
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      extest_out <= 1'b0;
      q_oe_out   <= 1'b0;
    end else if (ce_in) begin
      extest_out <= (ir_out == `SBT_OP_EXTEST);
      q_oe_out   <= (ir_out == `SBT_OP_EXTEST) &
                    ring_drive_out[OE_CELL];
    end
  end

  // serial source for the output, always the lsb of the chosen register
  always @* begin
    if (shift_ir) begin
      sdo_d = irs_q[0];
    end else if (sel_id) begin
      sdo_d = id_q[0];
    end else if (sel_bsr) begin
      sdo_d = bsr_q[0];
    end else begin
      sdo_d = byp_q;
    end
  end

  // serial output and its enable move only at a seen fall, so the far
  // side always finds a settled bit at its next rise
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (ce_in && fall) begin
      tdo_out    <= sdo_d;
      tdo_oe_out <= shift_ir | shift_dr;
    end
  end
endmodule // sbt_tap
`default_nettype wire

/* File: sim/sbt_host.sv */
// board test controller model on the test pins
// assumes it alone drives tck, tms and tdi
`timescale 1ns/100ps
`default_nettype none
module sbt_host (
  input  wire logic tdo_in,
  output var  logic tck_out, tms_out, tdi_out
);
  // tck stands low between frames; idle pins read high
  initial {tck_out, tms_out, tdi_out} = 3'b011;
  // one 125 ns period; tdo taken at the rise, pins moved while low
  task automatic bit_io(input logic m, d, output logic q);
    tms_out = m;
    tdi_out = d;
    #62.5 tck_out = 1'b1;
    q = tdo_in;
    #62.5 tck_out = 1'b0;
  endtask
  task automatic reset5;
    logic q;
    repeat (5) bit_io(1'b1, 1'b1, q);
  endtask
  // idle, select, capture, n shifts lsb first, update, idle
  task automatic scan(input logic ir, input int n,
                      input logic [127:0] din, output logic [127:0] dout);
    logic q;
    dout = '0;
    bit_io(1'b0, 1'b1, q);
    bit_io(1'b1, 1'b1, q);
    if (ir) bit_io(1'b1, 1'b1, q);
    bit_io(1'b0, 1'b1, q);
    bit_io(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_io(1'b1, 1'b1, q);
    bit_io(1'b0, 1'b1, q);
  endtask
endmodule // sbt_host
`default_nettype wire

/* File: sim/sbt_monitor.sv */
// assertions on the test port pins
// bound to sbt_tap; each tck phase spans 6.25 clk_in cycles
`timescale 1ns/100ps
`default_nettype none
module sbt_monitor (
  input wire logic       clk_in, rst_n_in, tck_in,
  input wire logic       tdo_out, tdo_oe_out, extest_out, q_oe_out,
  input wire logic [2:0] ir_out
);
  // outputs follow a seen edge by 2-4 clk, well inside each tck phase
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_tdo; $changed(tdo_out) |-> !tck_in; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo late");
  property p_oe; $changed(tdo_oe_out) |-> !tck_in; endproperty
  a_oe: assert property (p_oe) else $error("oe late");
  property p_ir; $changed(ir_out) |-> tck_in; endproperty
  a_ir: assert property (p_ir) else $error("ir late");
  property p_qoe; $changed(q_oe_out) |-> tck_in; endproperty
  a_qoe: assert property (p_qoe) else $error("q oe late");
  property p_gate; q_oe_out |-> extest_out; endproperty
  a_gate: assert property (p_gate) else $error("q oe leak");
  property p_ext;
    $stable(ir_out) |-> extest_out == (ir_out == 3'h0); endproperty
  a_ext: assert property (p_ext) else $error("extest code");
  property p_rst; $rose(rst_n_in) |-> ir_out == 3'h1 && !tdo_oe_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_one; tdo_oe_out |-> $stable(ir_out); endproperty
  a_one: assert property (p_one) else $error("ir moved");
endmodule // sbt_monitor
bind sbt_tap sbt_monitor mon_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .tck_in(tck_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .extest_out(extest_out), .q_oe_out(q_oe_out), .ir_out(ir_out));
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for sbt_tap through the host model
// assumes sbt_host and sbt_monitor compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [31:0] ID = 32'h0000_0001; // arbitrary value
  logic clk_in = 1'b0, rst_n_in = 1'b0;
  logic [109:0] ring = {11{10'h2B5}};
  logic [127:0] r;
  int errors = 0, samples_checked = 0;
  wire logic tck, tms, tdi, tdo, oe, ext, qoe;
  wire logic [2:0] ir;
  wire logic [109:0] drv;
  wire tdo_pin = oe ? tdo : 1'bz; // released pin floats
  always #5 clk_in = ~clk_in;
  sbt_host host_u (.tdo_in(tdo_pin), .tck_out(tck), .tms_out(tms),
    .tdi_out(tdi));
  sbt_tap #(.ID_VALUE(ID)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(oe), .ring_in(ring), .ring_drive_out(drv),
    .extest_out(ext), .q_oe_out(qoe), .ir_out(ir));
  task automatic check(input logic [127:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("%0d checks, %0d errors", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset;
    check(ir, 3'h1);
    check(oe, 1'b0);
    host_u.scan(1'b1, 3, 128'h0, r);
    check(r[1:0], 2'h1);
    check(qoe, 1'b0);
    $display("reset test done");
  endtask
  // bypass cell is cleared at capture, so output lags input by one bit
  task automatic t_bypass;
    host_u.scan(1'b1, 3, 128'h7, r);
    host_u.scan(1'b0, 4, 128'h5, r);
    check(r[3:0], 4'hA);
    host_u.scan(1'b0, 4, 128'h3, r);
    check(r[3:0], 4'h6);
    $display("bypass test done");
  endtask
  task automatic t_id;
    host_u.reset5();
    check(ir, 3'h1);
    host_u.scan(1'b0, 32, 128'h0, r);
    check(r[31:0], ID);
    $display("id test done");
  endtask
  // preload sets cell 109, so extest then drives the outputs
  task automatic t_ring;
    for (int c = 3; c >= 0; c--) begin
      if (c == 1) continue;
      host_u.scan(1'b1, 3, 128'(c), r);
      check(ir, 3'(c));
      host_u.scan(1'b0, 110, 128'h1 << 109, r);
      check(r[109:0], ring);
    end
    check(qoe, 1'b1);
    check(ext, 1'b1);
    check(drv, 110'h1 << 109);
    $display("ring test done");
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_bypass();
    t_id();
    t_ring();
    print_verdict();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    errors++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
